// file: ebt_pkg.sv
// shared constants, types and helpers for the external bus data/termination/arbitration ends
package ebt_pkg;
  // ****************************************
  // bus geometry
  // ****************************************
  localparam int DW     = 32;              // data lines
  localparam int LANES  = 4;               // byte lanes
  localparam int LANE_W = 8;               // bits per lane
  localparam int NC     = 7;               // single-bit control pins
  localparam int AW     = 5;               // attribute pins
  // control pin indices (all active low on the wire)
  localparam int C_TA  = 0;                // transfer_ack
  localparam int C_TEA = 1;                // transfer_error_ack
  localparam int C_BI  = 2;                // no_burst_flag
  localparam int C_BR  = 3;                // bus_request
  localparam int C_BG  = 4;                // bus_grant
  localparam int C_BB  = 5;                // bus_busy
  localparam int C_TS  = 6;                // transfer_start
  // attribute field: {write, transfer_size[1:0], addr_lo[1:0]}
  localparam int A_ALO = 0;
  localparam int A_SZ  = 2;
  localparam int A_WR  = 4;
  // transfer_size codes
  localparam logic [1:0] SZ_WORD = 2'h0;
  localparam logic [1:0] SZ_BYTE = 2'h1;
  localparam logic [1:0] SZ_HALF = 2'h2;
  localparam logic [1:0] SZ_TRI  = 2'h3;
  // ****************************************
  // register map of the device end
  // ****************************************
  localparam logic [7:0] REG_CTRL  = 8'h00;
  localparam logic [7:0] REG_CMD   = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_RDATA = 8'h0c;
  localparam logic [7:0] REG_STAT  = 8'h10;
  localparam logic [7:0] REG_SNOOP = 8'h14;
  localparam int CT_IARB = 0;              // internal arbiter enable
  localparam int CT_PCHK = 1;              // read parity check enable
  localparam int CT_ODD  = 2;              // odd parity when set
  localparam int CT_MCS  = 3;              // slave handled by memory controller
  localparam int CT_MCX  = 4;              // memory controller snoops external master data
  localparam logic [4:0] CTRL_RST = 5'h01;
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_TEA  = 2;
  localparam int ST_PAR  = 3;
  localparam int ST_MON  = 4;
  localparam int ST_SNP  = 5;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ****************************************
  // timing counts (cycles of i_ref_clk)
  // ****************************************
  localparam logic [5:0] MON_CYC = 6'h20;  // bus monitor limit
  localparam logic [5:0] MC_WAIT = 6'h02;  // memory controller wait states
  // ****************************************
  // state types
  // ****************************************
  typedef enum logic [5:0] {
    S_IDLE = 6'h01, S_REQ = 6'h02, S_START = 6'h04,
    S_DATA = 6'h08, S_END = 6'h10, S_EXT = 6'h20
  } ebt_dst_t;
  typedef enum logic [3:0] {
    SV_IDLE = 4'h1, SV_WAIT = 4'h2, SV_ACK = 4'h4, SV_NEG = 4'h8
  } ebt_sst_t;
  typedef enum logic [4:0] {
    MS_IDLE = 5'h01, MS_REQ = 5'h02, MS_START = 5'h04, MS_DATA = 5'h08, MS_END = 5'h10
  } ebt_mst_t;
  // lanes selected by low address bits and size
  function automatic logic [LANES-1:0] ebt_lane_mask(input logic [1:0] alo,
                                                     input logic [1:0] sz);
    logic [LANES-1:0] m;
    m = 4'hf;
    case (sz)
      SZ_BYTE: m = 4'h1 << alo;
      SZ_HALF: m = 4'h3 << alo;
      SZ_TRI:  m = 4'h7 << alo;
      default: m = 4'hf;
    endcase
    return m;
  endfunction : ebt_lane_mask
endpackage : ebt_pkg

// file: ebt_bus_if.sv
// wire-level carrier joining the device end and the far end
`timescale 1ns/100ps
interface ebt_bus_if (
  // bus clock, shared by both ends
  input logic bus_clock_out
);
  import ebt_pkg::*;
  logic [NC-1:0]    dev_c_o, dev_c_oe, oth_c_o, oth_c_oe, c;  // control pins
  logic [DW-1:0]    dev_d_o, dev_d_oe, oth_d_o, oth_d_oe, d;  // data lines
  logic [LANES-1:0] dev_p_o, dev_p_oe, oth_p_o, oth_p_oe, p;  // parity_lines
  logic [AW-1:0]    dev_a_o, oth_a_o, a;                      // attributes
  logic             dev_a_oe, oth_a_oe;
  // control pins float high through pull-ups
  assign c = (dev_c_oe & dev_c_o) | (~dev_c_oe & oth_c_oe & oth_c_o) | (~dev_c_oe & ~oth_c_oe);
  // data and parity float low
  assign d = (dev_d_oe & dev_d_o) | (~dev_d_oe & oth_d_oe & oth_d_o);
  assign p = (dev_p_oe & dev_p_o) | (~dev_p_oe & oth_p_oe & oth_p_o);
  assign a = dev_a_oe ? dev_a_o : (oth_a_oe ? oth_a_o : '0);
  modport dev (output dev_c_o, dev_c_oe, dev_d_o, dev_d_oe, dev_p_o, dev_p_oe, dev_a_o, dev_a_oe,
               input c, d, p, a, bus_clock_out);
  modport oth (output oth_c_o, oth_c_oe, oth_d_o, oth_d_oe, oth_p_o, oth_p_oe, oth_a_o, oth_a_oe,
               input c, d, p, a, bus_clock_out);
endinterface : ebt_bus_if

// file: ebt_far.sv
// far end: external slave, external master and optional external arbiter
`timescale 1ns/100ps
module ebt_far (
  // clock, reset, enable
  input  logic        i_ref_clk,
  input  logic        i_rst_b,
  input  logic        i_ce,
  // slave side
  input  logic        i_slv_en,
  input  logic        i_slv_err,
  input  logic        i_slv_nobrst,
  input  logic [3:0]  i_slv_wait,
  input  logic        i_odd_par,
  input  logic [31:0] i_slv_rdata,
  output logic [31:0] o_slv_wdata,
  output logic        o_slv_wr,
  // external arbiter
  input  logic        i_arb_en,
  // external master
  input  logic        i_mst_go,
  input  logic [31:0] i_mst_wdata,
  output logic        o_mst_busy,
  output logic        o_mst_done,
  // bus pins
  ebt_bus_if.oth      bus
);
  import ebt_pkg::*;
  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [NC-1:0]    c1, c2;        // control synchroniser
    logic [DW-1:0]    d1, d2;        // data synchroniser
    logic [AW-1:0]    a1, a2;        // attribute synchroniser
    ebt_sst_t         sst;           // slave state
    ebt_mst_t         mst;           // master state
    logic [AW-1:0]    sattr;         // attributes of the served cycle
    logic [3:0]       cnt;           // slave wait counter
    logic [NC-1:0]    c_o, c_oe;
    logic [DW-1:0]    d_o, d_oe;
    logic [LANES-1:0] p_o, p_oe;
    logic [AW-1:0]    a_o;
    logic             a_oe;
    logic [DW-1:0]    wdata;
    logic             wr, busy, done;
  } ebt_far_t;
  ebt_far_t q, n;                    // current and next state
  logic [LANES-1:0] w_rpar, w_mpar;  // lane parity of read and master data

  // per-lane parity for what this end drives
  for (genvar k = 0; k < LANES; k++) begin : g_lane
    assign w_rpar[k] = ^i_slv_rdata[LANE_W*k +: LANE_W] ^ i_odd_par;
    assign w_mpar[k] = ^i_mst_wdata[LANE_W*k +: LANE_W] ^ i_odd_par;
  end

  // next-state logic for slave, master and arbiter
  always_comb begin
    n      = q;
    n.c1   = bus.c;
    n.c2   = q.c1;
    n.d1   = bus.d;
    n.d2   = q.d1;
    n.a1   = bus.a;
    n.a2   = q.a1;
    n.wr   = 1'b0;
    n.done = 1'b0;
    // slave answers each transfer_start it sees
    unique case (q.sst)
      SV_IDLE: if (i_slv_en && !q.c2[C_TS]) begin
        n.sst   = SV_WAIT;
        n.sattr = q.a2;
        n.cnt   = '0;
      end
      SV_WAIT: if (q.cnt == i_slv_wait) begin
        n.sst = SV_ACK;
        if (q.sattr[A_WR]) begin     // data accepted with the acknowledge
          n.wdata = q.d2;
          n.wr    = 1'b1;
        end
      end else begin
        n.cnt = q.cnt + 4'h1;
      end
      SV_ACK:  n.sst = SV_NEG;
      SV_NEG:  n.sst = SV_IDLE;
    endcase
    // master: request, qualified grant, one word write
    unique case (q.mst)
      MS_IDLE:  if (i_mst_go) n.mst = MS_REQ;
      MS_REQ:   if (!q.c2[C_BG] && q.c2[C_BB]) n.mst = MS_START;
      MS_START: n.mst = MS_DATA;
      MS_DATA:  if (!q.c2[C_TA] || !q.c2[C_TEA]) begin
        n.mst  = MS_END;
        n.done = 1'b1;
      end
      MS_END:   n.mst = MS_IDLE;
    endcase
    n.busy = (n.mst != MS_IDLE);
    // pin drive, decided from next states
    n.c_o  = '1;
    n.c_oe = '0;
    n.c_oe[C_TA]  = (n.sst == SV_ACK) || (n.sst == SV_NEG);
    n.c_o[C_TA]   = !((n.sst == SV_ACK) && !i_slv_err);
    n.c_oe[C_TEA] = n.c_oe[C_TA];
    n.c_o[C_TEA]  = !((n.sst == SV_ACK) && i_slv_err);
    n.c_oe[C_BI]  = n.c_oe[C_TA];
    n.c_o[C_BI]   = !((n.sst == SV_ACK) && i_slv_nobrst);
    n.c_oe[C_BR]  = (n.mst == MS_REQ);
    n.c_o[C_BR]   = 1'b0;
    n.c_oe[C_BG]  = i_arb_en;
    n.c_o[C_BG]   = q.c2[C_BR];      // simple arbiter grants what is asked
    n.c_oe[C_BB]  = (n.mst == MS_START) || (n.mst == MS_DATA) || (n.mst == MS_END);
    n.c_o[C_BB]   = (n.mst == MS_END);
    n.c_oe[C_TS]  = n.c_oe[C_BB];
    n.c_o[C_TS]   = (n.mst != MS_START);
    n.a_oe        = n.c_oe[C_BB];
    n.a_o         = '0;
    n.a_o[A_WR]   = 1'b1;
    n.a_o[A_SZ +: 2] = SZ_WORD;
    // read data with its acknowledge, else master write data
    if (n.sst == SV_ACK && !q.sattr[A_WR]) begin
      n.d_o  = i_slv_rdata;
      n.d_oe = '1;
      n.p_o  = w_rpar;
      n.p_oe = '1;
    end else if (n.mst == MS_DATA) begin
      n.d_o  = i_mst_wdata;
      n.d_oe = '1;
      n.p_o  = w_mpar;
      n.p_oe = '1;
    end else begin
      n.d_oe = '0;
      n.p_oe = '0;
    end
  end

  // state register, frozen while the enable is low
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      q      <= '0;
      q.c1   <= '1;
      q.c2   <= '1;
      q.c_o  <= '1;
      q.sst  <= SV_IDLE;
      q.mst  <= MS_IDLE;
    end else if (i_ce) begin
      q <= n;
    end
  end

  assign bus.oth_c_o  = q.c_o;
  assign bus.oth_c_oe = q.c_oe;
  assign bus.oth_d_o  = q.d_o;
  assign bus.oth_d_oe = q.d_oe;
  assign bus.oth_p_o  = q.p_o;
  assign bus.oth_p_oe = q.p_oe;
  assign bus.oth_a_o  = q.a_o;
  assign bus.oth_a_oe = q.a_oe;
  assign o_slv_wdata  = q.wdata;
  assign o_slv_wr     = q.wr;
  assign o_mst_busy   = q.busy;
  assign o_mst_done   = q.done;
endmodule : ebt_far

// file: ebt_dev.sv
// device end: data phase, termination and arbitration, commanded over axi4-lite
// Functional notes
// - lane k holds data bits 8k to 8k+7
// - drive data only on own writes
// - slave drives reads; unselected lanes ignored
// - sample data for external masters when enabled (sampled only under the internal arbiter)
// - one parity line per byte lane
// - write parity per lane, even or odd
// - check selected lane parity on reads
// - slave acknowledges every beat, active low
// - memory controller drives ack and no-burst
// - slave reports errors with error acknowledge
// - bus monitor drives error acknowledge
// - slave flags no burst, active low
// - external master requests bus, active low
// - request driven only under external arbiter
// - internal arbiter grants to external master
// - owner needs grant and free busy (internal arbiter starts on the pending command alone)
// - qualified grant sampled before own transfer (only under the external arbiter; the internal arbiter starts at once)
// - busy asserted while owning the bus
// - busy negation ends external master tenure
// - all pins timed on rising bus clock
// - transfer start marks each own transfer
//
// The implementer's own choices: the address map and register access over AXI4-Lite.
`timescale 1ns/100ps
module ebt_dev (
  // clock, reset, enable
  input  logic        i_ref_clk,
  input  logic        i_rst_b,
  input  logic        i_ce,
  // axi4-lite write
  input  logic [7:0]  i_s_axi_awaddr,
  input  logic        i_s_axi_awvalid,
  output logic        o_s_axi_awready,
  input  logic [31:0] i_s_axi_wdata,
  input  logic [3:0]  i_s_axi_wstrb,
  input  logic        i_s_axi_wvalid,
  output logic        o_s_axi_wready,
  output logic [1:0]  o_s_axi_bresp,
  output logic        o_s_axi_bvalid,
  input  logic        i_s_axi_bready,
  // axi4-lite read
  input  logic [7:0]  i_s_axi_araddr,
  input  logic        i_s_axi_arvalid,
  output logic        o_s_axi_arready,
  output logic [31:0] o_s_axi_rdata,
  output logic [1:0]  o_s_axi_rresp,
  output logic        o_s_axi_rvalid,
  input  logic        i_s_axi_rready,
  // bus pins
  ebt_bus_if.dev      bus
);
  import ebt_pkg::*;
  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [NC-1:0]    c1, c2;        // control synchroniser
    logic [DW-1:0]    d1, d2;        // data synchroniser
    logic [LANES-1:0] p1, p2;        // parity synchroniser
    ebt_dst_t         st;            // bus state
    logic [4:0]       ctrl;          // control register
    logic [AW-1:0]    cmd;           // command attributes
    logic             go;            // command pending
    logic [DW-1:0]    wdat, rdat, snp;
    logic [5:0]       sts;           // status, sticky bits w1c
    logic             xtxn, bbseen;  // external tenure tracking
    logic             mcack, mtea;   // own termination to drive
    logic [5:0]       cnt;           // data phase cycle count
    logic [NC-1:0]    c_o, c_oe;
    logic [DW-1:0]    d_o, d_oe;
    logic [LANES-1:0] p_o, p_oe;
    logic [AW-1:0]    a_o;
    logic             a_oe;
    logic             awok, wok, awrdy, wrdy, bvld, arrdy, rvld;
    logic [7:0]       awa;           // held write address
    logic [DW-1:0]    wd, rd;        // held write data, read answer
    logic [3:0]       ws;            // held write strobes
    logic [1:0]       bresp, rresp;
  } ebt_dev_t;
  ebt_dev_t q, n;                    // current and next state
  logic [LANES-1:0] w_mask;          // lanes of the commanded transfer
  logic [DW-1:0]    w_mask32, w_bm;  // lane mask and strobe mask per bit
  logic [LANES-1:0] w_wpar, w_rpok;  // write parity, read parity match
  logic [DW-1:0]    w_rmrg;          // read data merged on selected lanes
  logic             w_qual;          // qualified grant
  assign w_mask = ebt_lane_mask(q.cmd[A_ALO +: 2], q.cmd[A_SZ +: 2]);
  assign w_qual = !q.c2[C_BG] && q.c2[C_BB];
  assign w_rmrg = (q.rdat & ~w_mask32) | (q.d2 & w_mask32);
  // ****************************************
  // per-lane mapping and parity
  // ****************************************
  for (genvar k = 0; k < LANES; k++) begin : g_lane
    assign w_mask32[LANE_W*k +: LANE_W] = {LANE_W{w_mask[k]}};
    assign w_bm[LANE_W*k +: LANE_W]     = {LANE_W{q.ws[k]}};
    assign w_wpar[k] = ^q.wdat[LANE_W*k +: LANE_W] ^ q.ctrl[CT_ODD];
    assign w_rpok[k] = (^q.d2[LANE_W*k +: LANE_W] ^ q.ctrl[CT_ODD]) == q.p2[k];
  end
  // next state: register slave, bus sequencer, pin drive
  always_comb begin
    n      = q;
    // pins pass two flip-flops, sampled on the rising edge
    n.c1   = bus.c;
    n.c2   = q.c1;
    n.d1   = bus.d;
    n.d2   = q.d1;
    n.p1   = bus.p;
    n.p2   = q.p1;
    // ****************************************
    // axi4-lite slave
    // ****************************************
    if (q.bvld && i_s_axi_bready) n.bvld = 1'b0;
    if (q.awrdy && i_s_axi_awvalid) begin
      n.awok = 1'b1;
      n.awa  = i_s_axi_awaddr;
    end
    if (q.wrdy && i_s_axi_wvalid) begin
      n.wok = 1'b1;
      n.wd  = i_s_axi_wdata;
      n.ws  = i_s_axi_wstrb;
    end
    // write takes effect once address and data are both held
    if (q.awok && q.wok && !q.bvld) begin
      n.awok  = 1'b0;
      n.wok   = 1'b0;
      n.bvld  = 1'b1;
      n.bresp = RESP_OKAY;
      case (q.awa)
        REG_CTRL:  if (q.ws[0]) n.ctrl = q.wd[4:0];
        REG_CMD:   if (q.go || q.st != S_IDLE) begin
          n.bresp = RESP_SLVERR;     // one transfer at a time
        end else if (q.ws[0]) begin
          n.cmd = q.wd[AW-1:0];
          n.go  = 1'b1;
        end
        REG_WDATA: n.wdat = (q.wdat & ~w_bm) | (q.wd & w_bm);
        REG_STAT:  if (q.ws[0]) n.sts = q.sts & ~q.wd[5:0];
        REG_RDATA, REG_SNOOP: n.bresp = RESP_OKAY;
        default:   n.bresp = RESP_SLVERR;
      endcase
    end
    n.awrdy = !n.awok && !n.bvld;
    n.wrdy  = !n.wok && !n.bvld;
    if (q.rvld && i_s_axi_rready) n.rvld = 1'b0;
    if (q.arrdy && i_s_axi_arvalid) begin
      n.rvld  = 1'b1;
      n.rresp = RESP_OKAY;
      n.rd    = '0;
      case (i_s_axi_araddr)
        REG_CTRL:  n.rd[4:0] = q.ctrl;
        REG_CMD:   n.rd[AW-1:0] = q.cmd;
        REG_WDATA: n.rd = q.wdat;
        REG_RDATA: n.rd = q.rdat;
        REG_STAT:  n.rd[5:0] = q.sts;
        REG_SNOOP: n.rd = q.snp;
        default:   n.rresp = RESP_SLVERR;
      endcase
    end
    n.arrdy = !n.rvld;
    // ****************************************
    // bus sequencer (status sets after clears, so a set wins)
    // ****************************************
    unique case (q.st)
      S_IDLE: begin
        if (q.go && (q.ctrl[CT_IARB] || w_qual)) begin  // parked or granted
          n.st = S_START;
          n.go = 1'b0;
        end else if (q.go) begin
          n.st = S_REQ;
        end else if (q.ctrl[CT_IARB] && !q.c2[C_BR]) begin
          n.st     = S_EXT;
          n.bbseen = 1'b0;
          n.xtxn   = 1'b0;
        end
      end
      S_REQ: if (w_qual) begin
        n.st = S_START;
        n.go = 1'b0;
      end
      S_START: begin
        n.st    = S_DATA;
        n.cnt   = '0;
        n.mcack = 1'b0;
        n.mtea  = 1'b0;
      end
      S_DATA: begin
        n.cnt = q.cnt + 6'h01;
        if (q.ctrl[CT_MCS] && q.cnt == MC_WAIT) begin
          n.mcack = 1'b1;
          n.st    = S_END;
        end else if (!q.ctrl[CT_MCS] && !q.c2[C_TEA]) begin
          n.sts[ST_TEA] = 1'b1;
          n.st          = S_END;
        end else if (!q.ctrl[CT_MCS] && !q.c2[C_TA]) begin
          n.st = S_END;
          if (!q.cmd[A_WR]) begin
            n.rdat = w_rmrg;
            if (q.ctrl[CT_PCHK] && |(w_mask & ~w_rpok)) n.sts[ST_PAR] = 1'b1;
          end
        end else if (q.cnt == MON_CYC) begin
          n.mtea        = 1'b1;
          n.sts[ST_MON] = 1'b1;
          n.st          = S_END;
        end
        if (n.st == S_END) n.sts[ST_DONE] = 1'b1;
      end
      S_END: n.st = S_IDLE;
      S_EXT: begin
        if (!q.c2[C_BB]) n.bbseen = 1'b1;
        if (!q.c2[C_TS] && q.ctrl[CT_MCX]) n.xtxn = 1'b1;
        if (q.xtxn && !q.c2[C_TA]) begin
          n.snp         = q.d2;
          n.sts[ST_SNP] = 1'b1;
          n.xtxn        = 1'b0;
        end
        // tenure ends on busy negation, or request dropped untaken
        if ((q.bbseen && q.c2[C_BB]) || (!q.bbseen && q.c2[C_BR] && q.c2[C_BB])) begin
          n.st = S_IDLE;
        end
      end
    endcase
    n.sts[ST_BUSY] = (n.st != S_IDLE) || n.go;
    // ****************************************
    // pin drive from the next state
    // ****************************************
    n.c_o  = '0;                     // request and terminations only ever drive low
    n.c_oe = '0;
    n.c_oe[C_BG] = q.ctrl[CT_IARB];
    n.c_o[C_BG]  = (n.st != S_EXT);
    n.c_oe[C_BR] = (n.st == S_REQ) && !q.ctrl[CT_IARB];
    n.c_oe[C_BB] = (n.st == S_START) || (n.st == S_DATA) || (n.st == S_END);
    n.c_o[C_BB]  = (n.st == S_END);
    n.c_oe[C_TS] = n.c_oe[C_BB];
    n.c_o[C_TS]  = (n.st != S_START);
    n.c_oe[C_TA] = (n.st == S_END) && n.mcack;
    n.c_oe[C_BI] = n.c_oe[C_TA];
    n.c_oe[C_TEA] = (n.st == S_END) && n.mtea;
    n.a_oe = n.c_oe[C_BB];
    n.a_o  = n.cmd;
    // write data only on own write, selected lanes only
    n.d_o  = q.wdat;
    n.p_o  = w_wpar;
    n.d_oe = (n.st == S_DATA && n.cmd[A_WR]) ? w_mask32 : '0;
    n.p_oe = (n.st == S_DATA && n.cmd[A_WR]) ? w_mask : '0;
  end
  // state register, frozen while the enable is low
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      q      <= '0;
      q.c1   <= '1;
      q.c2   <= '1;
      q.st   <= S_IDLE;
      q.ctrl <= CTRL_RST;
    end else if (i_ce) begin
      q <= n;
    end
  end
  assign bus.dev_c_o  = q.c_o;
  assign bus.dev_c_oe = q.c_oe;
  assign bus.dev_d_o  = q.d_o;
  assign bus.dev_d_oe = q.d_oe;
  assign bus.dev_p_o  = q.p_o;
  assign bus.dev_p_oe = q.p_oe;
  assign bus.dev_a_o  = q.a_o;
  assign bus.dev_a_oe = q.a_oe;
  assign o_s_axi_awready = q.awrdy;
  assign o_s_axi_wready  = q.wrdy;
  assign o_s_axi_bvalid  = q.bvld;
  assign o_s_axi_bresp   = q.bresp;
  assign o_s_axi_arready = q.arrdy;
  assign o_s_axi_rvalid  = q.rvld;
  assign o_s_axi_rdata   = q.rd;
  assign o_s_axi_rresp   = q.rresp;
endmodule : ebt_dev

// file: ebt_bus_monitor.sv
// checks on the wires between the two bus ends
`timescale 1ns/100ps
module ebt_bus_monitor import ebt_pkg::*; (
  // clock and reset
  input wire logic          bus_clock_out,
  input wire logic          i_rst_b,
  // resolved pins and enables
  input wire logic [NC-1:0] c,
  input wire logic [NC-1:0] dev_c_oe,
  input wire logic [NC-1:0] oth_c_oe,
  input wire logic [DW-1:0] dev_d_oe,
  input wire logic [DW-1:0] oth_d_oe,
  input wire logic [3:0]    dev_p_oe
);
  default clocking cb @(posedge bus_clock_out); endclocking
  default disable iff (!i_rst_b);
  // own start, and either kind of termination
  sequence own_ts; $fell(c[C_TS]) && dev_c_oe[C_TS]; endsequence
  sequence ended; !c[C_TA] || !c[C_TEA]; endsequence
  // bus monitor must end a silent transfer well inside this bound
  chk_xfer_ends: assert property (own_ts |-> ##[1:50] ended)
    else $error("no termination");
  chk_ts_single: assert property ($fell(c[C_TS]) |=> c[C_TS])
    else $error("long start");
  chk_ts_owned: assert property (!c[C_TS] |-> !c[C_BB])
    else $error("start while free");
  chk_ack_single: assert property ($fell(c[C_TA]) |=> c[C_TA])
    else $error("long ack");
  chk_data_owned: assert property (|dev_d_oe |-> !c[C_BB])
    else $error("data off tenure");
  chk_par_lanes: assert property
    (dev_p_oe == {dev_d_oe[24], dev_d_oe[16], dev_d_oe[8], dev_d_oe[0]})
    else $error("parity lane enable");
  chk_no_clash: assert property (!(|(dev_d_oe & oth_d_oe)))
    else $error("data contention");
  chk_busy_neg: assert property ($rose(c[C_BB]) |-> dev_c_oe[C_BB] || oth_c_oe[C_BB])
    else $error("busy not driven high");
  chk_grant_req: assert property ($fell(c[C_BG]) && dev_c_oe[C_BG] |-> !$past(c[C_BR], 2))
    else $error("grant without request");
  chk_req_dir: assert property (!(dev_c_oe[C_BR] && dev_c_oe[C_BG]))
    else $error("request while arbiter");
  chk_mc_nobrst: assert property (dev_c_oe[C_TA] |-> !c[C_TA] && !c[C_BI])
    else $error("memory controller answer incomplete");
endmodule : ebt_bus_monitor

// file: tb.sv
// self-checking bench joining the device end to the far end
`timescale 1ns/100ps
module tb;
  import ebt_pkg::*;
  logic        clk, rst_b, awv, wv, bry, arv, rry, awr, wrd, bv, arr, rv;
  logic        s_en, s_err, odd, arb, go, s_wr, m_busy, m_done;
  logic [1:0]  bresp, rresp, wrsp, rrsp;
  logic [7:0]  awa, ara;
  logic [31:0] wd, rd_q, s_rd, s_wd, m_wd, st, v;
  int          errors, check_count, n;
  ebt_bus_if bus_i (.bus_clock_out(clk));
  ebt_dev ebt_dev_i (.i_ref_clk(clk), .i_rst_b(rst_b), .i_ce(1'b1), .i_s_axi_awaddr(awa),
    .i_s_axi_awvalid(awv), .o_s_axi_awready(awr), .i_s_axi_wdata(wd), .i_s_axi_wstrb(4'hf),
    .i_s_axi_wvalid(wv), .o_s_axi_wready(wrd), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bv),
    .i_s_axi_bready(bry), .i_s_axi_araddr(ara), .i_s_axi_arvalid(arv), .o_s_axi_arready(arr),
    .o_s_axi_rdata(rd_q), .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rv), .i_s_axi_rready(rry),
    .bus(bus_i.dev));
  ebt_far ebt_far_i (.i_ref_clk(clk), .i_rst_b(rst_b), .i_ce(1'b1), .i_slv_en(s_en),
    .i_slv_err(s_err), .i_slv_nobrst(1'b0), .i_slv_wait(4'h2), .i_odd_par(odd),
    .i_slv_rdata(s_rd), .o_slv_wdata(s_wd), .o_slv_wr(s_wr), .i_arb_en(arb), .i_mst_go(go),
    .i_mst_wdata(m_wd), .o_mst_busy(m_busy), .o_mst_done(m_done), .bus(bus_i.oth));
  ebt_bus_monitor ebt_bus_monitor_i (.bus_clock_out(clk), .i_rst_b(rst_b), .c(bus_i.c),
    .dev_c_oe(bus_i.dev_c_oe), .oth_c_oe(bus_i.oth_c_oe), .dev_d_oe(bus_i.dev_d_oe),
    .oth_d_oe(bus_i.oth_d_oe), .dev_p_oe(bus_i.dev_p_oe));
  task chk(input string nm, input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task complete_run();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : complete_run
  // a wait that ran out ends the run
  task limit();
    if (n >= 200) begin
      errors++;
      complete_run();
    end
  endtask : limit
  // axi write: both channels offered together, bready held until bvalid
  task wr(input logic [7:0] ad, input logic [31:0] x);
    @(posedge clk);
    n = 0;
    awa <= ad;
    wd <= x;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (awr) awv <= 1'b0;
      if (wrd) wv <= 1'b0;
    end while (bv !== 1'b1 && n < 200);
    wrsp = bresp;
    bry <= 1'b0;
    limit();
  endtask : wr
  task rd(input logic [7:0] ad, output logic [31:0] x);
    @(posedge clk);
    n = 0;
    ara <= ad;
    arv <= 1'b1;
    rry <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (arr) arv <= 1'b0;
    end while (rv !== 1'b1 && n < 200);
    x = rd_q;
    rrsp = rresp;
    rry <= 1'b0;
    limit();
  endtask : rd
  // set control, clear status, launch one transfer and poll for done
  task xfer(input logic [4:0] ctl, input logic [4:0] cmd);
    int k;
    wr(REG_CTRL, {27'h0, ctl});
    wr(REG_STAT, 32'h3e);
    wr(REG_WDATA, 32'h5a3c9617);
    wr(REG_CMD, {27'h0, cmd});
    k = 0;
    do begin
      rd(REG_STAT, st);
      k++;
    end while (st[ST_DONE] !== 1'b1 && k < 100);
    if (k >= 100) n = 200;
    limit();
  endtask : xfer
  task t_write();
    xfer(5'h01, {1'b1, SZ_BYTE, 2'h2});
    chk("lane2", {24'h0, s_wd[23:16]}, 32'h3c);
    wr(8'h1c, 32'h0);
    chk("unmapped wr", {30'h0, wrsp}, {30'h0, RESP_SLVERR});
    rd(8'h1c, v);
    chk("unmapped rdata", v, 32'h0);
    chk("unmapped rresp", {30'h0, rrsp}, {30'h0, RESP_SLVERR});
    $display("write test ended");
  endtask : t_write
  // half read with parity check, then with the far end on the other sense
  task t_read();
    xfer(5'h03, {1'b0, SZ_HALF, 2'h0});
    chk("par ok", {31'h0, st[ST_PAR]}, 32'h0);
    rd(REG_RDATA, v);
    chk("rdata", {16'h0, v[15:0]}, 32'hc3d4);
    odd <= 1'b1;
    xfer(5'h03, {1'b0, SZ_HALF, 2'h0});
    chk("par bad", {31'h0, st[ST_PAR]}, 32'h1);
    odd <= 1'b0;
    $display("read test ended");
  endtask : t_read
  // slave error, silent slave, then memory controller answering
  task t_term();
    s_err <= 1'b1;
    xfer(5'h01, 5'h10);
    chk("tea", {31'h0, st[ST_TEA]}, 32'h1);
    s_err <= 1'b0;
    s_en <= 1'b0;
    xfer(5'h01, 5'h10);
    chk("mon", {31'h0, st[ST_MON]}, 32'h1);
    xfer(5'h09, 5'h10);
    chk("mc", {31'h0, st[ST_MON]}, 32'h0);
    s_en <= 1'b1;
    $display("termination test ended");
  endtask : t_term
  // external master write snooped under the internal arbiter
  task t_ext();
    wr(REG_CTRL, 32'h11);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (m_done !== 1'b1 && n < 200);
    limit();
    rd(REG_SNOOP, v);
    chk("snoop", v, m_wd);
    chk("bus free", {31'h0, bus_i.c[C_BB]}, 32'h1);
    chk("mst idle", {31'h0, m_busy}, 32'h0);
    arb <= 1'b1;
    xfer(5'h00, 5'h10);
    chk("ext arb", {31'h0, st[ST_MON]}, 32'h0);
    $display("arbitration test ended");
  endtask : t_ext
  initial begin
    {clk, rst_b, awv, wv, bry, arv, rry, s_err, odd, arb, go} = '0;
    {awa, ara, wd, errors, check_count} = '0;
    s_en = 1'b1;
    s_rd = 32'ha1b2c3d4;
    m_wd = 32'h1e2d4b87;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    t_write();
    t_read();
    t_term();
    t_ext();
    complete_run();
  end
  initial forever #12.5 clk = ~clk;
endmodule : tb
